//--- verilog/strobe_timer_map.vh
`ifndef STROBE_TIMER_MAP_VH
`define STROBE_TIMER_MAP_VH

// ==========================================================
// register port
`define REG_ADDR_W 4
`define REG_CFG_FIRST 4'h0
`define REG_CFG_SECOND 4'h1
`define REG_STATUS 4'h2
`define REG_LAST_RDATA 4'h3
`define REG_UNMAPPED_VALUE 8'h00

// ==========================================================
// field positions
`define WSETUP_MSB 2
`define WSETUP_LSB 0
`define WPULSE_MSB 5
`define WPULSE_LSB 3
`define WHOLD_LO_MSB 7
`define WHOLD_LO_LSB 6
`define WHOLD_HI_BIT 0
`define RSETUP_MSB 3
`define RSETUP_LSB 1
`define RPULSE_MSB 6
`define RPULSE_LSB 4

// ==========================================================
// reset values: read setup 0, read pulse 2
`define CFG_FIRST_RESET 8'h00
`define CFG_SECOND_RESET 8'h20

// ==========================================================
// fixed timing for selector-steered accesses
`define DIRECT_SETUP 3'h0
`define DIRECT_PULSE 3'h2
`define DIRECT_HOLD 3'h0

// ==========================================================
// status byte bits
`define STAT_BUSY 0
`define STAT_DIRECT 1
`define STAT_WRITE 2

// ==========================================================
// sequencer
`define SPAN_W 5
`define ST_IDLE 1'b0
`define ST_RUN 1'b1
`define SPAN_ONE 5'h01
`define READ_HOLD 3'h0

`endif

//--- verilog/strobe_phase.v
`timescale 1ns/1ps
`include "strobe_timer_map.vh"

// ==========================================================
// active-low strobe: asserts on the falling edge after
// window rises, releases on the rising edge where it falls
module strobe_phase
(
	input wire ref_clk,
	input wire rst,
	input wire window,
	output wire strobe_n
);

	reg late;

	always @(negedge ref_clk or posedge rst)
	begin
		if (rst)
			late <= 1'b0;
		else
			late <= window;
	end

	// gating by window gives the rising-edge release
	assign strobe_n = ~(window & late);

endmodule // strobe_phase

//--- verilog/strobe_config_regs.v
`timescale 1ns/1ps
`include "strobe_timer_map.vh"

// ==========================================================
// configuration and status registers
module strobe_config_regs
(
	input wire ref_clk,
	input wire rst,
	input wire [`REG_ADDR_W-1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] status,
	input wire [7:0] last_rdata,
	output reg [7:0] cfg_first,
	output reg [7:0] cfg_second,
	output reg [7:0] reg_rdata
);

	reg [7:0] next_rdata;

	always @*
	begin
		case (reg_addr)
			`REG_CFG_FIRST: next_rdata = cfg_first;
			`REG_CFG_SECOND: next_rdata = cfg_second;
			`REG_STATUS: next_rdata = status;
			`REG_LAST_RDATA: next_rdata = last_rdata;
			default: next_rdata = `REG_UNMAPPED_VALUE;
		endcase
	end

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			cfg_first <= `CFG_FIRST_RESET;
			cfg_second <= `CFG_SECOND_RESET;
			reg_rdata <= `REG_UNMAPPED_VALUE;
		end
		else
		begin
			if (reg_wr && reg_addr == `REG_CFG_FIRST)
				cfg_first <= reg_wdata;
			if (reg_wr && reg_addr == `REG_CFG_SECOND)
				cfg_second <= reg_wdata;
			// read data valid only the cycle after the strobe
			if (reg_rd)
				reg_rdata <= next_rdata;
			else
				reg_rdata <= `REG_UNMAPPED_VALUE;
		end
	end

endmodule // strobe_config_regs

//--- verilog/external_memory_strobe_timer.v
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "strobe_timer_map.vh"

module external_memory_strobe_timer
(
	input wire ref_clk,
	input wire rst,
	input wire [`REG_ADDR_W-1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output wire [7:0] reg_rdata,
	input wire req_valid,
	input wire req_write,
	input wire req_direct,
	input wire [15:0] req_addr,
	input wire [7:0] req_wdata,
	output reg req_ready,
	output reg done,
	output reg [7:0] rd_data,
	output reg [15:0] mem_addr,
	output reg mem_ce_n,
	output wire mem_oe_n,
	output wire mem_we_n,
	output reg [7:0] mem_dout,
	output reg mem_doe,
	input wire [7:0] mem_din
);

	// ==========================================================
	// state
	reg state;
	reg [`SPAN_W-1:0] elapsed;
	reg [`SPAN_W-1:0] span;
	reg [2:0] setup;
	reg [2:0] pulse;
	reg is_write;
	reg is_direct;
	reg oe_win;
	reg we_win;
	reg next_state;
	reg [`SPAN_W-1:0] next_elapsed;
	reg [`SPAN_W-1:0] next_span;
	reg [2:0] next_setup;
	reg [2:0] next_pulse;
	reg next_is_write;
	reg next_is_direct;
	reg next_ready;
	reg next_done;
	reg [7:0] next_rd_data;
	reg [15:0] next_addr;
	reg next_ce_n;
	reg [7:0] next_dout;
	reg next_doe;
	reg next_in_win;
	reg [2:0] pick_setup;
	reg [2:0] pick_pulse;
	reg [2:0] pick_hold;
	wire [7:0] cfg_first;
	wire [7:0] cfg_second;
	wire [7:0] status;
	wire [2:0] rsetup;
	wire [2:0] rpulse;
	wire [2:0] wsetup;
	wire [2:0] wpulse;
	wire [2:0] whold;
	wire [`SPAN_W-1:0] win_end;
	wire [`SPAN_W-1:0] span_setup;
	wire [`SPAN_W-1:0] span_pulse;
	wire [`SPAN_W-1:0] span_hold;

	// ==========================================================
	// configuration fields
	assign rsetup = cfg_second[`RSETUP_MSB:`RSETUP_LSB];
	assign rpulse = cfg_second[`RPULSE_MSB:`RPULSE_LSB];
	assign wsetup = cfg_first[`WSETUP_MSB:`WSETUP_LSB];
	assign wpulse = cfg_first[`WPULSE_MSB:`WPULSE_LSB];
	assign whold = {cfg_second[`WHOLD_HI_BIT],
		cfg_first[`WHOLD_LO_MSB:`WHOLD_LO_LSB]};

	// busy is the inverse of ready
	assign status = {5'h00, is_write, is_direct, ~req_ready};

	strobe_config_regs regs
	(
		.ref_clk(ref_clk),
		.rst(rst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.status(status),
		.last_rdata(rd_data),
		.cfg_first(cfg_first),
		.cfg_second(cfg_second),
		.reg_rdata(reg_rdata)
	);

	// ==========================================================
	// field choice per access
	// fields are latched when the access is taken; a config
	// write during an access only shapes the next one
	always @*
	begin
		if (req_direct)
		begin
			// selectors bring their own handshake timing
			pick_setup = `DIRECT_SETUP;
			pick_pulse = `DIRECT_PULSE;
			pick_hold = `DIRECT_HOLD;
		end
		else if (req_write)
		begin
			pick_setup = wsetup;
			pick_pulse = wpulse;
			pick_hold = whold;
		end
		else
		begin
			pick_setup = rsetup;
			pick_pulse = rpulse;
			pick_hold = `READ_HOLD; // read ends with output-enable
		end
	end

	// ==========================================================
	// widened picks for the span sum
	assign span_setup = {{(`SPAN_W-3){1'b0}}, pick_setup};
	assign span_pulse = {{(`SPAN_W-3){1'b0}}, pick_pulse};
	assign span_hold = {{(`SPAN_W-3){1'b0}}, pick_hold};

	// ==========================================================
	// sequencer
	// requests seen while busy are dropped, not queued, so the
	// requester holds req_valid until req_ready comes back
	always @*
	begin
		next_state = state;
		next_elapsed = elapsed;
		next_span = span;
		next_setup = setup;
		next_pulse = pulse;
		next_is_write = is_write;
		next_is_direct = is_direct;
		next_ready = req_ready;
		next_done = 1'b0;
		next_rd_data = rd_data;
		next_addr = mem_addr;
		next_ce_n = mem_ce_n;
		next_dout = mem_dout;
		next_doe = mem_doe;
		case (state)
			`ST_IDLE:
			begin
				if (req_valid)
				begin
					next_state = `ST_RUN;
					next_elapsed = {`SPAN_W{1'b0}};
					next_setup = pick_setup;
					next_pulse = pick_pulse;
					// chip-enable spans setup, pulse, hold and one
					next_span = span_setup + span_pulse + span_hold
						+ `SPAN_ONE;
					next_is_write = req_write;
					next_is_direct = req_direct;
					next_ready = 1'b0;
					next_addr = req_addr;
					next_ce_n = 1'b0;
					next_dout = req_wdata;
					next_doe = req_write;
				end
			end
			`ST_RUN:
			begin
				if (elapsed + `SPAN_ONE == span)
				begin
					next_state = `ST_IDLE;
					next_ce_n = 1'b1;
					next_doe = 1'b0;
					next_ready = 1'b1;
					next_done = 1'b1;
					// sampled on the edge that releases output-enable
					if (!is_write)
						next_rd_data = mem_din;
				end
				else
					next_elapsed = elapsed + `SPAN_ONE;
			end
			default:
			begin
				next_state = `ST_IDLE;
				next_ce_n = 1'b1;
				next_doe = 1'b0;
				next_ready = 1'b1;
			end
		endcase
	end

	// ==========================================================
	// strobe windows, counted from the chip-enable edge
	// window spans elapsed setup to setup+pulse; strobe_phase
	// trims its first half cycle
	assign win_end = {2'b00, next_setup} + {2'b00, next_pulse} + `SPAN_ONE;

	always @*
	begin
		next_in_win = (next_state == `ST_RUN)
			&& (next_elapsed >= {2'b00, next_setup})
			&& (next_elapsed < win_end);
	end

	// ==========================================================
	// sequencer registers
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state <= `ST_IDLE;
			elapsed <= {`SPAN_W{1'b0}};
			span <= {`SPAN_W{1'b0}};
			setup <= 3'h0;
			pulse <= 3'h0;
			is_write <= 1'b0;
			is_direct <= 1'b0;
		end
		else
		begin
			state <= next_state;
			elapsed <= next_elapsed;
			span <= next_span;
			setup <= next_setup;
			pulse <= next_pulse;
			is_write <= next_is_write;
			is_direct <= next_is_direct;
		end
	end

	// ==========================================================
	// pin and handshake registers
	// address and data only move when a new access is taken
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			oe_win <= 1'b0;
			we_win <= 1'b0;
			req_ready <= 1'b1;
			done <= 1'b0;
			rd_data <= 8'h00;
			mem_addr <= 16'h0000;
			mem_ce_n <= 1'b1;
			mem_dout <= 8'h00;
			mem_doe <= 1'b0;
		end
		else
		begin
			oe_win <= next_in_win & ~next_is_write;
			we_win <= next_in_win & next_is_write;
			req_ready <= next_ready;
			done <= next_done;
			rd_data <= next_rd_data;
			mem_addr <= next_addr;
			mem_ce_n <= next_ce_n;
			mem_dout <= next_dout;
			mem_doe <= next_doe;
		end
	end

	// ==========================================================
	// half-cycle strobes
	// each strobe is the AND of a rising-edge window and its
	// falling-edge copy; a single flop cannot give the half cycle
	strobe_phase oe_strobe
	(
		.ref_clk(ref_clk),
		.rst(rst),
		.window(oe_win),
		.strobe_n(mem_oe_n)
	);

	strobe_phase we_strobe
	(
		.ref_clk(ref_clk),
		.rst(rst),
		.window(we_win),
		.strobe_n(mem_we_n)
	);

endmodule // external_memory_strobe_timer

//--- verification/ext_async_mem.sv
`timescale 1ns/1ps
// ==========================================================
// byte-wide asynchronous memory, low address byte decoded
module ext_async_mem
(
	input wire [15:0] mem_addr,
	input wire mem_ce_n,
	input wire mem_oe_n,
	input wire mem_we_n,
	input wire [7:0] mem_dout,
	output wire [7:0] mem_din
);
	logic [7:0] cells [0:255];
	// stores while selected and write strobe low; level-sensitive so
	// a zero write hold, where both strobes rise on one edge, is safe
	always @(mem_ce_n or mem_we_n or mem_addr or mem_dout)
		if (mem_ce_n === 1'b0 && mem_we_n === 1'b0)
			cells[mem_addr[7:0]] = mem_dout;
	// released bus shows the inverse, so stale data never matches
	assign mem_din = (!mem_ce_n && !mem_oe_n) ? cells[mem_addr[7:0]]
		: ~cells[mem_addr[7:0]];
endmodule // ext_async_mem

//--- verification/strobe_timer_chk.sv
`timescale 1ns/1ps
// ==========================================================
// strobe sequence checks
module strobe_timer_chk
(
	input wire ref_clk,
	input wire rst,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire req_valid,
	input wire req_write,
	input wire req_direct,
	input wire req_ready,
	input wire done,
	input wire [15:0] mem_addr,
	input wire mem_ce_n,
	input wire mem_oe_n,
	input wire mem_we_n,
	input wire [7:0] mem_dout,
	input wire mem_doe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire take = req_valid && req_ready && req_direct;
	chk_direct_read: assert property (take && !req_write |=>
		!mem_ce_n [*3] ##1 mem_ce_n) else $error("direct read length");
	chk_direct_write: assert property (take && req_write |=>
		!mem_we_n [*3] ##1 mem_we_n) else $error("direct write length");
	chk_strobe_in_ce: assert property (
		!mem_oe_n || !mem_we_n |-> !mem_ce_n) else $error("strobe outside ce");
	chk_oe_ce_end: assert property (
		$rose(mem_oe_n) |-> $rose(mem_ce_n)) else $error("oe ce end apart");
	chk_ce_done: assert property (
		$rose(mem_ce_n) |-> done) else $error("no done at ce end");
	chk_addr_hold: assert property (
		!mem_ce_n && $past(!mem_ce_n) |-> $stable(mem_addr))
		else $error("address moved");
	chk_data_hold: assert property (
		!mem_ce_n && mem_doe && $past(!mem_ce_n) |-> $stable(mem_dout))
		else $error("write data moved");
	chk_doe_end: assert property (
		$fell(mem_doe) |-> $rose(mem_ce_n)) else $error("doe end early");
	chk_rdata_idle: assert property (
		!reg_rd |=> reg_rdata == 8'h00) else $error("stray read data");
	cov_read: cover property (take && !req_write);
	cov_write: cover property (take && req_write);
	cov_reg_read: cover property (reg_rd);
endmodule // strobe_timer_chk

bind external_memory_strobe_timer strobe_timer_chk i_chk(.ref_clk, .rst,
	.reg_rd, .reg_rdata, .req_valid, .req_write, .req_direct, .req_ready,
	.done, .mem_addr, .mem_ce_n, .mem_oe_n, .mem_we_n, .mem_dout, .mem_doe);

//--- verification/external_memory_strobe_timer_tb_top.sv
`timescale 1ns/1ps
module external_memory_strobe_timer_tb_top;
	logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
	logic req_valid = 0, req_write = 0, req_direct = 0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, req_wdata = 8'h00;
	logic [15:0] req_addr = 16'h0000;
	wire [7:0] reg_rdata, rd_data, mem_dout, mem_din;
	wire [15:0] mem_addr;
	wire req_ready, done, mem_ce_n, mem_oe_n, mem_we_n, mem_doe;
	int miscompares = 0, tests_run = 0, cycles = 0;
	int cfg [4][3] = '{'{0, 2, 0}, '{3, 5, 2}, '{1, 1, 1}, '{7, 7, 7}};

	external_memory_strobe_timer i_dut(.ref_clk, .rst, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .req_valid, .req_write,
		.req_direct, .req_addr, .req_wdata, .req_ready, .done, .rd_data,
		.mem_addr, .mem_ce_n, .mem_oe_n, .mem_we_n, .mem_dout, .mem_doe,
		.mem_din);
	ext_async_mem i_mem(.mem_addr, .mem_ce_n, .mem_oe_n, .mem_we_n,
		.mem_dout, .mem_din);

	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			miscompares++;
			finish_test;
		end
	end

	task finish_test;
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] v, e);
		tests_run++;
		if (v !== e)
		begin
			miscompares++;
			$display("mismatch at %0t: got %h exp %h", $time, v, e);
		end
	endtask

	// ==========================================================
	// register port
	task automatic rw(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rr(input logic [3:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
		@(posedge ref_clk);
		#1 chk(reg_rdata, 8'h00);
	endtask

	// ==========================================================
	// one memory access; samples a quarter cycle after each edge
	// so a strobe asserted on the rising edge counts one too many
	task automatic acc(input logic w, dr, input logic [15:0] a,
		input logic [7:0] d, input int s, p, h);
		int n, k, f;
		n = 0;
		k = 0;
		f = -1;
		req_valid <= 1'b1;
		req_write <= w;
		req_direct <= dr;
		req_addr <= a;
		req_wdata <= d;
		@(posedge ref_clk);
		req_valid <= 1'b0;
		for (int i = 0; i < 40; i++)
		begin
			#25;
			if (done === 1'b1)
				break;
			chk(req_ready, 1'b0);
			if (!mem_ce_n)
				n++;
			chk(mem_addr, a);
			chk(mem_doe, w);
			if (w)
				chk(mem_dout, d);
			if (!(w ? mem_we_n : mem_oe_n))
			begin
				k++;
				if (f < 0)
					f = i;
			end
			@(posedge ref_clk);
		end
		chk(n, s + p + h + 1);
		chk(k, p);
		if (p > 0)
			chk(f, s + 1);
		chk(done, 1'b1);
		chk(req_ready, 1'b1);
		chk(mem_doe, 1'b0);
		if (!w)
			chk(rd_data, d);
		@(posedge ref_clk);
	endtask

	initial
	begin
		logic [2:0] s, p, h;
		logic [15:0] a;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rr(4'h0, 8'h00);
		rr(4'h1, 8'h20);
		rr(4'h2, 8'h00);
		rr(4'h5, 8'h00);
		acc(1, 0, 16'h1234, 8'h9e, 0, 0, 0);
		acc(0, 0, 16'h1234, 8'h9e, 0, 2, 0);
		foreach (cfg[i])
		begin
			s = cfg[i][0][2:0];
			p = cfg[i][1][2:0];
			h = cfg[i][2][2:0];
			a = 16'h5a00 + 16'(i);
			rw(4'h0, {h[1:0], p, s});
			rw(4'h1, {1'b0, p, s, h[2]});
			rr(4'h0, {h[1:0], p, s});
			rr(4'h1, {1'b0, p, s, h[2]});
			acc(1, 0, a, 8'hc3 ^ 8'(i), s, p, h);
			acc(0, 0, a, 8'hc3 ^ 8'(i), s, p, 0);
		end
		acc(1, 1, 16'h0077, 8'h3c, 0, 2, 0);
		acc(0, 1, 16'h0077, 8'h3c, 0, 2, 0);
		// status after a direct read: direct set, write and busy clear
		rr(4'h2, 8'h02);
		rr(4'h3, 8'h3c);
		finish_test;
	end
endmodule // external_memory_strobe_timer_tb_top
